/* File: verilog/ata_task_file_decode.sv */
// host-side register decode of the parallel disk port
`default_nettype none
module ata_task_file_decode
  import task_file_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire host_bus_s host,
  input wire logic hw_reset_n,
  input wire logic [15:0] data_in,
  input wire logic [7:0] last_error_flags,
  input wire logic [6:0] status_low,
  input wire logic [7:0] legacy_drive_address,
  input wire logic [15:0] buffer_rd_word,
  input wire logic busy_clear,
  output logic [15:0] data_out,
  output logic [15:0] data_oe,
  output logic wide_transfer_ind_n,
  output logic drive_busy_flag,
  output logic [7:0] feature_select,
  output logic [7:0] transfer_sector_count,
  output logic [7:0] sector_index_lba_low,
  output logic [7:0] cylinder_low_lba_mid,
  output logic [7:0] cylinder_high_lba_upper,
  output logic [7:0] drive_head_select,
  output logic [7:0] command_entry,
  output logic command_strobe,
  output logic [7:0] interface_control,
  output logic [15:0] buffer_wr_word,
  output logic buffer_wr_strobe,
  output logic buffer_rd_strobe
);
  tf_state_s s_q, s_d;
  logic cmd_sel, ctl_sel, rd_now, wr_now;
  logic [7:0] stat;
  localparam int BUSY_WIN = BUSY_DELAY_CYC;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  // R03 command block decode, R16 both or neither selects nothing
  assign cmd_sel = !host.command_block_select_n &&
                   host.control_block_select_n;
  assign ctl_sel = host.command_block_select_n &&
                   !host.control_block_select_n;
  assign rd_now = !host.read_strobe_n;
  assign wr_now = !host.write_strobe_n;
  // R13 busy reported in status bit 7
  assign stat = {s_q.drive_busy_flag, status_low};

  always_comb begin
    s_d = s_q;
    s_d.wr_q = wr_now;
    s_d.rd_q = rd_now;
    s_d.hw_reset_q = !hw_reset_n;
    s_d.command_strobe = 1'b0;
    s_d.data_wr_strobe = 1'b0;
    s_d.data_rd_strobe = 1'b0;
    s_d.dout = WORD_RESET;
    s_d.doe = WORD_RESET;
    // R07 wide indication follows address match to data register
    s_d.wide_transfer_ind_n = !(cmd_sel &&
                                host.register_index_lines == IDX_DATA);
    // R04 read map, R14 unused bits zero
    if (rd_now && cmd_sel) begin
      s_d.doe = LOW_BYTE_EN;
      unique case (host.register_index_lines)
        // R15 data register is a full word
        IDX_DATA: begin
          s_d.dout = buffer_rd_word;
          s_d.doe = WORD_EN;
        end
        IDX_ERR_FEAT: s_d.dout = {8'h00, last_error_flags};
        IDX_COUNT: s_d.dout = {8'h00, s_q.transfer_sector_count};
        IDX_SECTOR: s_d.dout = {8'h00, s_q.sector_index_lba_low};
        IDX_CYL_LO: s_d.dout = {8'h00, s_q.cylinder_low_lba_mid};
        IDX_CYL_HI: s_d.dout = {8'h00, s_q.cylinder_high_lba_upper};
        IDX_HEAD: s_d.dout = {8'h00, s_q.drive_head_select};
        IDX_STAT_CMD: s_d.dout = {8'h00, stat};
      endcase
    end else if (rd_now && ctl_sel) begin
      // R16 indexes 0 to 5 stay released
      if (host.register_index_lines == IDX_SHADOW_CTL) begin
        s_d.dout = {8'h00, stat};
        s_d.doe = LOW_BYTE_EN;
      end else if (host.register_index_lines == IDX_LEGACY_ADDR) begin
        // R09 R10 answered for compatibility, R11 bit 7 released
        s_d.dout = {9'h000, legacy_drive_address[DATA_BIT7-1:0]};
        s_d.doe = LEGACY_EN;
      end
    end
    // a buffer read pulse once per strobe, on its leading edge
    if (rd_now && !s_q.rd_q && cmd_sel &&
        host.register_index_lines == IDX_DATA)
      s_d.data_rd_strobe = 1'b1;
    // writes take effect on the trailing edge, data is stable there
    if (s_q.wr_q && !wr_now) begin
      if (cmd_sel) begin
        // R04 write map, R05 address bytes shared with chs fields
        unique case (host.register_index_lines)
          IDX_DATA: begin
            s_d.sector_data_port = data_in;
            s_d.data_wr_strobe = 1'b1;
          end
          IDX_ERR_FEAT: s_d.feature_select = data_in[7:0];
          IDX_COUNT: s_d.transfer_sector_count = data_in[7:0];
          IDX_SECTOR: s_d.sector_index_lba_low = data_in[7:0];
          IDX_CYL_LO: s_d.cylinder_low_lba_mid = data_in[7:0];
          IDX_CYL_HI: s_d.cylinder_high_lba_upper = data_in[7:0];
          IDX_HEAD: s_d.drive_head_select = data_in[7:0];
          IDX_STAT_CMD: begin
            s_d.command_entry = data_in[7:0];
            s_d.command_strobe = 1'b1;
          end
        endcase
      end else if (ctl_sel &&
                   host.register_index_lines == IDX_SHADOW_CTL) begin
        // R17 only the control register takes writes
        s_d.interface_control = data_in[7:0];
      end
    end
    // R13 busy raised one edge after reset release, well inside bound
    if (busy_clear)
      s_d.drive_busy_flag = 1'b0;
    if (s_q.hw_reset_q && hw_reset_n)
      s_d.drive_busy_flag = 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
      s_q.wide_transfer_ind_n <= 1'b1;
      s_q.drive_busy_flag <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign data_out = s_q.dout;
  assign data_oe = s_q.doe;
  assign wide_transfer_ind_n = s_q.wide_transfer_ind_n;
  assign drive_busy_flag = s_q.drive_busy_flag;
  assign feature_select = s_q.feature_select;
  assign transfer_sector_count = s_q.transfer_sector_count;
  assign sector_index_lba_low = s_q.sector_index_lba_low;
  assign cylinder_low_lba_mid = s_q.cylinder_low_lba_mid;
  assign cylinder_high_lba_upper = s_q.cylinder_high_lba_upper;
  assign drive_head_select = s_q.drive_head_select;
  assign command_entry = s_q.command_entry;
  assign command_strobe = s_q.command_strobe;
  assign interface_control = s_q.interface_control;
  assign buffer_wr_word = s_q.sector_data_port;
  assign buffer_wr_strobe = s_q.data_wr_strobe;
  assign buffer_rd_strobe = s_q.data_rd_strobe;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_wide_ind_match: assert property (@(posedge mclk) disable iff (rst) // R07
    (cmd_sel && host.register_index_lines == IDX_DATA) |=>
    !wide_transfer_ind_n) else $error("wide indication missing");
  a_busy_after_rst: assert property (@(posedge mclk) disable iff (rst) // R13
    ($rose(hw_reset_n) && $past(!hw_reset_n)) |-> ##[1:BUSY_WIN]
    drive_busy_flag) else $error("busy late after reset");
  a_bit7_released: assert property (@(posedge mclk) disable iff (rst) // R11
    (rd_now && ctl_sel && host.register_index_lines == IDX_LEGACY_ADDR)
    |=> data_oe == LEGACY_EN) else $error("bit 7 driven");
  a_no_sel_quiet: assert property (@(posedge mclk) disable iff (rst) // R16
    (!cmd_sel && !ctl_sel) |=> data_oe == WORD_RESET)
    else $error("bus driven without select");
  a_ctl_low_quiet: assert property (@(posedge mclk) disable iff (rst) // R16
    (ctl_sel && host.register_index_lines < IDX_SHADOW_CTL) |=>
    data_oe == WORD_RESET) else $error("control low index driven");
  a_unused_zero: assert property (@(posedge mclk) disable iff (rst) // R14
    (data_oe == LOW_BYTE_EN) |-> data_out[15:8] == 8'h00)
    else $error("unused bits nonzero");
  a_ctl_wr_drop: assert property (@(posedge mclk) disable iff (rst) // R17
    (s_q.wr_q && !wr_now && ctl_sel &&
     host.register_index_lines != IDX_SHADOW_CTL) |=>
    $stable(interface_control)) else $error("control write taken");
  a_cmd_write: assert property (@(posedge mclk) disable iff (rst) // R04
    (s_q.wr_q && !wr_now && cmd_sel &&
     host.register_index_lines == IDX_STAT_CMD) |=>
    command_strobe && command_entry == $past(data_in[7:0]))
    else $error("command not taken");
  a_data_word: assert property (@(posedge mclk) disable iff (rst) // R15
    (rd_now && cmd_sel && host.register_index_lines == IDX_DATA) |=>
    data_oe == WORD_EN) else $error("data not full word");
  a_lba_low: assert property (@(posedge mclk) disable iff (rst) // R05
    (s_q.wr_q && !wr_now && cmd_sel &&
     host.register_index_lines == IDX_SECTOR) |=>
    sector_index_lba_low == $past(data_in[7:0]))
    else $error("address low byte lost");
  a_busy_status: assert property (@(posedge mclk) disable iff (rst) // R13
    (rd_now && cmd_sel && host.register_index_lines == IDX_STAT_CMD) |=>
    data_out[BUSY_BIT] == $past(drive_busy_flag))
    else $error("busy missing from status");
  a_rd_pulse_once: assert property (@(posedge mclk) disable iff (rst) // R15
    (rd_now && s_q.rd_q) |=> !buffer_rd_strobe)
    else $error("buffer read pulsed twice");
  a_feat_write: assert property (@(posedge mclk) disable iff (rst) // R04
    (s_q.wr_q && !wr_now && cmd_sel &&
     host.register_index_lines == IDX_ERR_FEAT) |=>
    feature_select == $past(data_in[7:0]))
    else $error("features write lost");
  a_wide_release: assert property (@(posedge mclk) disable iff (rst) // R07
    !(cmd_sel && host.register_index_lines == IDX_DATA) |=>
    wide_transfer_ind_n) else $error("wide indication stuck");
  a_data_wr_word: assert property (@(posedge mclk) disable iff (rst) // R15
    (s_q.wr_q && !wr_now && cmd_sel &&
     host.register_index_lines == IDX_DATA) |=>
    buffer_wr_strobe && buffer_wr_word == $past(data_in))
    else $error("data word write lost");
endmodule : ata_task_file_decode
`default_nettype wire

/* File: shared/task_file_pkg.sv */
// constants and carriers for the task file decode block
// ----------------------------------------------------------------------
// Behaviour
// R01: host puts index on address lines, asserts one select, then one strobe
// R02: host uses control select only for shadow status and control
// R03: command select low and control select high reach all other registers
// R04: index 0 data, 1 error/features, 7 status/command, 2-6 same both ways
// R05: indexes 3-6 hold block address bits 0-7, 8-15, 16-23, 24-27
// R06: isa adapter forms selects from io ranges, aen and a3
// R07: wide transfer indication low whenever data register is addressed
// R08: host uses upper byte lanes only while wide indication is active
// R09: obsolete drive address read should not be answered
// R10: this drive answers obsolete drive address reads for compatibility
// R11: drive leaves data bit 7 undriven on obsolete drive address reads
// R12: host holds reset low at least the minimum pulse width
// R13: busy flag set within 400 ns of reset going inactive
// R14: unused write bits ignored, unused read bits read as zero
// R15: data register is a 16-bit path to the sector buffer
// R16: both or neither select means no register and released data bus
// R17: writes to control block other than control register are discarded
// ----------------------------------------------------------------------
`default_nettype none
package task_file_pkg;
  localparam logic [2:0] IDX_DATA = 3'h0;
  localparam logic [2:0] IDX_ERR_FEAT = 3'h1;
  localparam logic [2:0] IDX_COUNT = 3'h2;
  localparam logic [2:0] IDX_SECTOR = 3'h3;
  localparam logic [2:0] IDX_CYL_LO = 3'h4;
  localparam logic [2:0] IDX_CYL_HI = 3'h5;
  localparam logic [2:0] IDX_HEAD = 3'h6;
  localparam logic [2:0] IDX_STAT_CMD = 3'h7;
  localparam logic [2:0] IDX_SHADOW_CTL = 3'h6;
  localparam logic [2:0] IDX_LEGACY_ADDR = 3'h7;
  localparam int BUSY_BIT = 7;
  localparam int DATA_BIT7 = 7;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] LOW_BYTE_EN = 16'h00FF;
  localparam logic [15:0] WORD_EN = 16'hFFFF;
  localparam logic [15:0] LEGACY_EN = 16'h007F;
  localparam int CLK_PERIOD_NS = 8;
  localparam int BUSY_DELAY_MAX_NS = 400;
  localparam int BUSY_DELAY_CYC = BUSY_DELAY_MAX_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic command_block_select_n;
    logic control_block_select_n;
    logic [2:0] register_index_lines;
    logic read_strobe_n;
    logic write_strobe_n;
  } host_bus_s;

  typedef struct packed {
    logic [15:0] dout;
    logic [15:0] doe;
    logic wide_transfer_ind_n;
    logic wr_q;
    logic [7:0] feature_select;
    logic [7:0] transfer_sector_count;
    logic [7:0] sector_index_lba_low;
    logic [7:0] cylinder_low_lba_mid;
    logic [7:0] cylinder_high_lba_upper;
    logic [7:0] drive_head_select;
    logic [7:0] command_entry;
    logic [7:0] interface_control;
    logic [15:0] sector_data_port;
    logic command_strobe;
    logic data_wr_strobe;
    logic data_rd_strobe;
    logic rd_q;
    logic drive_busy_flag;
    logic hw_reset_q;
  } tf_state_s;
endpackage : task_file_pkg
`default_nettype wire

/* File: verification/host_model.sv */
// host controller model driving register cycles into the port
`default_nettype none
module host_model
  import task_file_pkg::*;
(
  input wire logic mclk,
  output var host_bus_s host,
  output logic [15:0] data_in,
  output logic hw_reset_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    host = '{1'b1, 1'b1, 3'h0, 1'b1, 1'b1};
    data_in = 16'h0000;
    hw_reset_n = 1'b1;
  end
  // selects decoded from an io address, aen taken inactive
  function automatic logic [1:0] sel(input logic [9:0] a);
    sel = {a[9:3] != 7'h3E, a[9:3] != 7'h7E};
  endfunction : sel
  // index, select pair and one strobe set together, held two edges
  task automatic go_sel(input logic [1:0] cs, input logic [2:0] idx,
                        input logic wr, input logic [15:0] v);
    @(posedge mclk);
    #1;
    {host.command_block_select_n, host.control_block_select_n} = cs;
    host.register_index_lines = idx;
    host.read_strobe_n = wr;
    host.write_strobe_n = !wr;
    data_in = v;
    repeat (2) @(posedge mclk);
    #1;
  endtask : go_sel
  // at most one select from the io address
  task automatic go(input logic [9:0] a, input logic wr,
                    input logic [15:0] v);
    go_sel(sel(a), a[2:0], wr, v);
  endtask : go
  task automatic idle();
    host.read_strobe_n = 1'b1;
    host.write_strobe_n = 1'b1;
    @(posedge mclk);
    #1;
    host.command_block_select_n = 1'b1;
    host.control_block_select_n = 1'b1;
    // released data lines must not keep the last value
    data_in = ~data_in;
  endtask : idle
  // reset pin held low for the minimum width
  task automatic pulse_reset(input int cyc);
    @(posedge mclk);
    #1;
    hw_reset_n = 1'b0;
    repeat (cyc) @(posedge mclk);
    #1;
    hw_reset_n = 1'b1;
  endtask : pulse_reset
endmodule : host_model
`default_nettype wire

/* File: verification/test_ata_task_file_decode.sv */
// self-checking bench for the task file decode block
`default_nettype none
module test_ata_task_file_decode
  import task_file_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [2:0] idx; logic [7:0] v;} row_s;
  logic mclk, rst, hw_reset_n, busy_clear, wide_n, busy, cmd_p, bw_p, br_p;
  host_bus_s host;
  logic [15:0] data_in, dout, doe, bw_word;
  logic [7:0] feat, cnt, sec, c_lo, c_hi, head, cmd, ictl;
  logic [7:0] err = 8'h5A, leg = 8'hC3;
  logic [6:0] stl = 7'h29;
  logic [15:0] brw = 16'hBEEF;
  int n_errors = 0, tests_run = 0, n_cmd = 0, n_bw = 0, n_br = 0, k;
  row_s rows [5] = '{'{3'h2, 8'h01}, '{3'h3, 8'h80}, '{3'h4, 8'hFF},
                     '{3'h5, 8'h3C}, '{3'h6, 8'hE7}};
  ata_task_file_decode ata_task_file_decode_i (.mclk(mclk), .rst(rst),
    .host(host), .hw_reset_n(hw_reset_n), .data_in(data_in),
    .last_error_flags(err), .status_low(stl), .legacy_drive_address(leg),
    .buffer_rd_word(brw), .busy_clear(busy_clear), .data_out(dout),
    .data_oe(doe), .wide_transfer_ind_n(wide_n), .drive_busy_flag(busy),
    .feature_select(feat), .transfer_sector_count(cnt),
    .sector_index_lba_low(sec), .cylinder_low_lba_mid(c_lo),
    .cylinder_high_lba_upper(c_hi), .drive_head_select(head),
    .command_entry(cmd), .command_strobe(cmd_p), .interface_control(ictl),
    .buffer_wr_word(bw_word), .buffer_wr_strobe(bw_p),
    .buffer_rd_strobe(br_p));
  host_model host_model_i (.mclk(mclk), .host(host), .data_in(data_in),
    .hw_reset_n(hw_reset_n));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    n_cmd += (cmd_p === 1'b1);
    n_bw += (bw_p === 1'b1);
    n_br += (br_p === 1'b1);
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic wr(input logic [9:0] a, input logic [15:0] v);
    host_model_i.go(a, 1'b1, v);
    host_model_i.idle();
    @(posedge mclk);
    #1;
  endtask : wr
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    busy_clear = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(doe, 16'h0000);
    chk({busy, wide_n, cnt}, 10'h300);
    rst = 1'b0;
    foreach (rows[i]) begin
      wr({7'h3E, rows[i].idx}, {8'hA5, rows[i].v});
      host_model_i.go({7'h3E, rows[i].idx}, 1'b0, 16'h0000);
      chk(dout, {8'h00, rows[i].v});
      chk(doe, LOW_BYTE_EN);
      host_model_i.idle();
    end
    chk({cnt, sec, c_lo, c_hi}, 32'h0180FF3C);
    chk(head, 8'hE7);
    // a second reset in mid-run must clear the loaded count register
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk({busy, wide_n, cnt}, 10'h300);
    rst = 1'b0;
    @(posedge mclk);
    #1;
    busy_clear = 1'b1;
    @(posedge mclk);
    #1;
    busy_clear = 1'b0;
    wr(10'h1F1, 16'h0077);
    chk(feat, 8'h77);
    host_model_i.go(10'h1F1, 1'b0, 16'h0000);
    chk(dout, {8'h00, err});
    host_model_i.idle();
    host_model_i.go(10'h1F7, 1'b0, 16'h0000);
    chk(dout, {9'h000, stl});
    chk(wide_n, 1'b1);
    host_model_i.idle();
    wr(10'h1F7, 16'h00EC);
    chk({n_cmd[7:0], cmd}, 16'h01EC);
    wr(10'h1F0, 16'h1234);
    chk(bw_word, 16'h1234);
    chk(n_bw[15:0], 16'h0001);
    host_model_i.go(10'h1F0, 1'b0, 16'h0000);
    chk(dout, brw);
    chk(doe, WORD_EN);
    chk(wide_n, 1'b0);
    chk(n_br[15:0], 16'h0001);
    host_model_i.idle();
    wr(10'h3F6, 16'h0006);
    wr(10'h3F2, 16'h0011);
    chk({ictl, cnt}, 16'h0600);
    host_model_i.go(10'h3F6, 1'b0, 16'h0000);
    chk(dout, {9'h000, stl});
    host_model_i.idle();
    host_model_i.go(10'h3F3, 1'b0, 16'h0000);
    chk(doe, 16'h0000);
    host_model_i.idle();
    host_model_i.go(10'h000, 1'b0, 16'h0000);
    chk(doe, 16'h0000);
    host_model_i.idle();
    // both selects low is an invalid pairing and reaches nothing
    host_model_i.go_sel(2'b00, IDX_DATA, 1'b0, 16'h0000);
    chk(doe, 16'h0000);
    chk(wide_n, 1'b1);
    chk(n_br[15:0], 16'h0001);
    host_model_i.idle();
    host_model_i.go(10'h3F7, 1'b0, 16'h0000);
    chk(doe, LEGACY_EN);
    chk(dout & 16'h007F, {9'h000, leg[6:0]});
    host_model_i.idle();
    // 25 us at the 8 ns clock
    host_model_i.pulse_reset(3125);
    k = 0;
    while (busy !== 1'b1 && k < BUSY_DELAY_CYC) begin
      @(posedge mclk);
      #1;
      k++;
    end
    chk(busy, 1'b1);
    close_out();
  end
endmodule : test_ata_task_file_decode
`default_nettype wire
